// ---- rtl/period_timer_pwm_defines.vh ----
`ifndef PERIOD_TIMER_PWM_DEFINES_VH
`define PERIOD_TIMER_PWM_DEFINES_VH

// ****************************************
// Unit modes
// ****************************************
`define MODE_OFF 2'h0
`define MODE_PWM 2'h1
`define MODE_CAPTURE 2'h2
`define MODE_COMPARE 2'h3

// ****************************************
// Capture edge prescale select
// ****************************************
`define PRE_EVERY_1 2'h0
`define PRE_EVERY_4 2'h1
`define PRE_EVERY_16 2'h2
`define PRE_EVERY_FALL 2'h3

// ****************************************
// Reset values and timebase wrap value
// ****************************************
`define TIMER_RESET 8'h00
`define TIMEBASE_RESET 16'h0000
`define TIMEBASE_MAX 16'hffff

`endif

// ---- rtl/period_timer_pwm_and_capture.v ----
`timescale 1ns/1ps
`default_nettype none
`include "period_timer_pwm_defines.vh"
module period_timer_pwm_and_capture (
    input wire CLK_SYS,
    input wire NRST,
    input wire [1:0] MODE,
    input wire MODE_WE,
    input wire TIMER_ON,
    input wire [7:0] PERIOD_LIMIT_REGISTER,
    input wire [7:0] DUTY_VALUE_REGISTER,
    input wire PIN_DIRECTION_OUTPUT,
    input wire [1:0] CAPTURE_PRESCALE,
    input wire CAPTURE_PIN,
    input wire [15:0] COMPARE_VALUE,
    input wire SPECIAL_EVENT_EN,
    input wire MATCH_FLAG_CLR,
    input wire CAPTURE_FLAG_CLR,
    input wire OVERFLOW_FLAG_CLR,
    output reg PWM_PIN_O,
    output reg PWM_PIN_OE,
    output reg [7:0] PERIOD_TIMER,
    output reg [15:0] CAPTURE_TIMEBASE,
    output reg [15:0] CAPTURE_VALUE,
    output reg PERIOD_MATCH_FLAG,
    output reg CAPTURE_EVENT_FLAG,
    output reg TIMEBASE_OVERFLOW_FLAG,
    output reg [1:0] MODE_STATE
);

    // ****************************************
    // Input synchroniser and edge detect
    // ****************************************
    reg cap_meta_q;
    reg cap_sync_q;
    reg cap_prev_q;
    reg [3:0] edge_cnt_q;
    reg [3:0] edge_cnt_d;
    reg cap_fire;
    wire rise = cap_sync_q & ~cap_prev_q;
    wire fall = ~cap_sync_q & cap_prev_q;
    wire capture_mode = (MODE_STATE == `MODE_CAPTURE);

    always @* begin
        edge_cnt_d = edge_cnt_q;
        cap_fire = 1'b0;
        case (CAPTURE_PRESCALE)
            `PRE_EVERY_1: begin
                cap_fire = rise;
            end
            `PRE_EVERY_FALL: begin
                cap_fire = fall;
            end
            `PRE_EVERY_4: begin
                if (rise) begin
                    edge_cnt_d = edge_cnt_q + 4'h1;
                    cap_fire = (edge_cnt_q[1:0] == 2'h3);
                end
            end
            default: begin
                if (rise) begin
                    edge_cnt_d = edge_cnt_q + 4'h1;
                    cap_fire = (edge_cnt_q == 4'hf);
                end
            end
        endcase
        if (!capture_mode) begin
            edge_cnt_d = 4'h0;
            cap_fire = 1'b0;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            cap_meta_q <= 1'b0;
            cap_sync_q <= 1'b0;
            cap_prev_q <= 1'b0;
            edge_cnt_q <= 4'h0;
        end else begin
            // Two stages before any logic sees the pin
            cap_meta_q <= CAPTURE_PIN;
            cap_sync_q <= cap_meta_q;
            cap_prev_q <= cap_sync_q;
            edge_cnt_q <= edge_cnt_d;
        end
    end

    // ****************************************
    // Mode register
    // ****************************************
    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            MODE_STATE <= `MODE_OFF;
        end else if (MODE_WE) begin
            MODE_STATE <= MODE;
        end
    end

    // ****************************************
    // Period timer and pulse output
    // ****************************************
    // match detect on current count
    wire period_match = TIMER_ON && (PERIOD_TIMER == PERIOD_LIMIT_REGISTER);
    wire pwm_mode = (MODE_STATE == `MODE_PWM);

    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            PERIOD_TIMER <= `TIMER_RESET;
            PERIOD_MATCH_FLAG <= 1'b0;
            PWM_PIN_O <= 1'b0;
            PWM_PIN_OE <= 1'b0;
        end else begin
            // clear then count up; ffh rolls naturally
            // limit is only read here, never reloaded by hardware
            if (period_match) begin
                PERIOD_TIMER <= `TIMER_RESET;
            end else if (TIMER_ON) begin
                PERIOD_TIMER <= PERIOD_TIMER + 8'h01;
            end
            if (period_match) begin
                PERIOD_MATCH_FLAG <= 1'b1;
            end else if (MATCH_FLAG_CLR) begin
                PERIOD_MATCH_FLAG <= 1'b0;
            end
            // pulse uses only the period timer
            if (!pwm_mode) begin
                PWM_PIN_O <= 1'b0;
            end else if (period_match) begin
                PWM_PIN_O <= 1'b1;
            end else if (TIMER_ON && (PERIOD_TIMER + 8'h01 == DUTY_VALUE_REGISTER)) begin
                // duty above limit never reached, stays high
                PWM_PIN_O <= 1'b0;
            end
            // drive only when pin set as output
            PWM_PIN_OE <= pwm_mode & PIN_DIRECTION_OUTPUT;
        end
    end

    // ****************************************
    // Timebase, capture and special event
    // ****************************************
    wire compare_mode = (MODE_STATE == `MODE_COMPARE);
    wire cmp_hit = compare_mode && (CAPTURE_TIMEBASE == COMPARE_VALUE);
    wire wrap = (CAPTURE_TIMEBASE == `TIMEBASE_MAX);

    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            CAPTURE_TIMEBASE <= `TIMEBASE_RESET;
            CAPTURE_VALUE <= `TIMEBASE_RESET;
            CAPTURE_EVENT_FLAG <= 1'b0;
            TIMEBASE_OVERFLOW_FLAG <= 1'b0;
        end else begin
            if (cmp_hit && SPECIAL_EVENT_EN) begin
                CAPTURE_TIMEBASE <= `TIMEBASE_RESET;
            end else begin
                CAPTURE_TIMEBASE <= CAPTURE_TIMEBASE + 16'h0001;
            end
            if (cap_fire) begin
                CAPTURE_VALUE <= CAPTURE_TIMEBASE;
            end
            // flag set even when interrupt unused
            if (cap_fire || cmp_hit) begin
                CAPTURE_EVENT_FLAG <= 1'b1;
            end else if (CAPTURE_FLAG_CLR) begin
                CAPTURE_EVENT_FLAG <= 1'b0;
            end
            // overflow flag only on genuine wrap
            if (wrap) begin
                TIMEBASE_OVERFLOW_FLAG <= 1'b1;
            end else if (OVERFLOW_FLAG_CLR) begin
                TIMEBASE_OVERFLOW_FLAG <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ---- bench/period_timer_pwm_and_capture_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module period_timer_pwm_and_capture_sva (
    input wire logic CLK_SYS, NRST, MODE_WE, TIMER_ON, PIN_DIRECTION_OUTPUT,
    input wire logic PWM_PIN_O, PWM_PIN_OE, PERIOD_MATCH_FLAG, CAPTURE_EVENT_FLAG,
    input wire logic [1:0] MODE_STATE,
    input wire logic [7:0] PERIOD_LIMIT_REGISTER, DUTY_VALUE_REGISTER, PERIOD_TIMER,
    input wire logic [15:0] CAPTURE_TIMEBASE, CAPTURE_VALUE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    wire pwm = MODE_STATE == 2'h1 && !MODE_WE;
    wire hit = TIMER_ON && PERIOD_TIMER == PERIOD_LIMIT_REGISTER;
    AST_CLR: assert property (hit |=> PERIOD_TIMER == 8'h00)
        else $error("period timer did not clear");
    AST_FLAG: assert property (hit |=> PERIOD_MATCH_FLAG)
        else $error("match flag not set");
    AST_INC: assert property ($past(NRST) && TIMER_ON && PERIOD_TIMER < PERIOD_LIMIT_REGISTER
        |=> PERIOD_TIMER == $past(PERIOD_TIMER) + 8'h01) else $error("timer step");
    AST_FULL: assert property (pwm && PWM_PIN_O && DUTY_VALUE_REGISTER > PERIOD_LIMIT_REGISTER
        && PERIOD_TIMER <= PERIOD_LIMIT_REGISTER |=> PWM_PIN_O) else $error("full duty");
    AST_HIGH: assert property (pwm && hit |=> PWM_PIN_O)
        else $error("output not high at clear");
    AST_LOW: assert property (pwm && TIMER_ON && !hit
        && PERIOD_TIMER + 8'h01 == DUTY_VALUE_REGISTER |=> !PWM_PIN_O) else $error("low");
    AST_OE: assert property (PWM_PIN_OE |-> $past(PIN_DIRECTION_OUTPUT))
        else $error("pin driven as input");
    AST_TB: assert property ($past(NRST) && MODE_STATE != 2'h3 && !MODE_WE
        |=> CAPTURE_TIMEBASE == $past(CAPTURE_TIMEBASE) + 16'h0001) else $error("tb");
    AST_CAP: assert property ($changed(CAPTURE_VALUE)
        |-> CAPTURE_VALUE == $past(CAPTURE_TIMEBASE) && CAPTURE_EVENT_FLAG) else $error("cap");
    cover property (hit);
    cover property (pwm && hit && PWM_PIN_O);
    cover property ($changed(CAPTURE_VALUE));
endmodule
bind period_timer_pwm_and_capture period_timer_pwm_and_capture_sva chk_u (.*);
`default_nettype wire

// ---- bench/pulse_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
    input wire logic clk, en, drv, drv_en,
    output logic pin,
    output wire logic load_lvl
);
    logic [2:0] cnt_q = 3'h0;
    assign load_lvl = drv_en ? drv : 1'b0;
    initial pin = 1'b0;
    // Toggle every 8 cycles, just after the edge
    always @(posedge clk) begin
        if (en) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) pin <= #1 ~pin;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_period_timer_pwm_and_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_period_timer_pwm_and_capture;
    logic clk = 0, nrst = 0, we = 0, ton = 0, dir = 0, sev = 0, mclr = 0, cclr = 0, oclr = 0;
    logic en = 0, cap_pin, pin_o, pin_oe, mflag, cflag, oflag, load_lvl;
    logic [1:0] mode = 0, pre = 0, mst;
    logic [7:0] lim = 0, duty = 0, ptmr;
    logic [15:0] cmp = 0, tb, capv, first;
    int err_total = 0, n_tests = 0;
    period_timer_pwm_and_capture dut_u (.CLK_SYS(clk), .NRST(nrst), .MODE(mode), .MODE_WE(we),
        .TIMER_ON(ton), .PERIOD_LIMIT_REGISTER(lim), .DUTY_VALUE_REGISTER(duty),
        .PIN_DIRECTION_OUTPUT(dir), .CAPTURE_PRESCALE(pre), .CAPTURE_PIN(cap_pin),
        .COMPARE_VALUE(cmp), .SPECIAL_EVENT_EN(sev), .MATCH_FLAG_CLR(mclr),
        .CAPTURE_FLAG_CLR(cclr), .OVERFLOW_FLAG_CLR(oclr), .PWM_PIN_O(pin_o),
        .PWM_PIN_OE(pin_oe), .PERIOD_TIMER(ptmr), .CAPTURE_TIMEBASE(tb), .CAPTURE_VALUE(capv),
        .PERIOD_MATCH_FLAG(mflag), .CAPTURE_EVENT_FLAG(cflag),
        .TIMEBASE_OVERFLOW_FLAG(oflag), .MODE_STATE(mst));
    pulse_source_model src_u (.clk(clk), .en(en), .drv(pin_o), .drv_en(pin_oe),
        .pin(cap_pin), .load_lvl(load_lvl));
    initial forever #2 clk = ~clk;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task test_done;
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task set_mode(input logic [1:0] m);
        mode = m; we = 1; cclr = 1; step(1); we = 0; cclr = 0;
    endtask
    task wait_flag;
        for (int k = 0; k < 700 && cflag !== 1'b1; k++) step(1);
    endtask
    // Waits for a fresh clear so duty and limit apply from a period start
    task pwm_run(input logic [7:0] l, input logic [7:0] d, input logic o);
        lim = l; duty = d; dir = o; mclr = 1; step(1); mclr = 0;
        for (int k = 0; k < 600 && ptmr !== l; k++) step(1);
        step(1);
        chk(mflag, 1);
        chk(pin_oe, o);
        for (int i = 0; i < 6; i++) begin
            chk(ptmr, i % (l + 1));
            chk(load_lvl, o && (i % (l + 1) < d || d > l));
            step(1);
        end
    endtask
    initial begin
        step(2);
        nrst = 1;
        set_mode(2'h1); ton = 1;
        pwm_run(8'h02, 8'h01, 1); pwm_run(8'h02, 8'h03, 1);
        pwm_run(8'hff, 8'h80, 1); pwm_run(8'h02, 8'h01, 0);
        set_mode(2'h2); en = 1;
        // difference of two captures, timebase never cleared
        for (int p = 0; p < 4; p++) begin
            pre = p; cclr = 1; step(1); cclr = 0; wait_flag; first = capv;
            cclr = 1; step(1); cclr = 0; wait_flag;
            chk(capv - first, p == 3 ? 16 : 16 << (2 * p));
        end
        // Flag cleared again here: a capture may land on the mode-change edge
        set_mode(2'h3); sev = 1; oclr = 1; cclr = 1; cmp = tb + 16'h0010; step(1);
        oclr = 0; cclr = 0;
        wait_flag;
        chk(cflag, 1);
        chk(tb, 0); chk(oflag, 0);
        nrst = 0; step(1);
        chk(mst, 0);
        chk(cflag, 0); chk(ptmr, 0);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
